// *** pkg/evlog_pkg.sv ***
package evlog_pkg;
    // storage and record layout
    localparam int DEPTH = 512;
    localparam int NUM_W = 16;
    localparam int TYPE_W = 4;
    localparam int FAULT_W = 8;
    localparam int DT_W = 32;
    localparam int MODE_W = 3;
    localparam int STAT_W = 8;
    localparam int HRS_W = 32;
    localparam int PAGE_W = 64;
    localparam int SNAP_W = 320;
    localparam int HDR_PAGES = 2;
    localparam int PAGE1_PAD_W = PAGE_W - HRS_W - STAT_W - MODE_W;
    localparam logic [NUM_W-1:0] EVNUM_RESET = 16'h0000;

    // event sources, also the stored event type code
    localparam int N_SRC = 12;
    localparam int SRC_PGM = 0;
    localparam int SRC_PERIODIC = 1;
    localparam int SRC_MODE = 2;
    localparam int SRC_SHUTDOWN = 3;
    localparam int SRC_LOADDUMP = 4;
    localparam int SRC_WARNING = 5;
    localparam int SRC_MAINS_FAIL = 6;
    localparam int SRC_MAINS_RESTORE = 7;
    localparam int SRC_ENG_START = 8;
    localparam int SRC_ENG_STOP = 9;
    localparam int SRC_ON_LOAD = 10;
    localparam int SRC_OFF_LOAD = 11;

    // synchronised pin lanes
    localparam int N_PIN = 8;
    localparam int PIN_REMOTE = 0;
    localparam int PIN_SIMULATE = 1;
    localparam int PIN_FORCED = 2;
    localparam int PIN_MENU = 3;
    localparam int PIN_PAGE_NEXT = 4;
    localparam int PIN_PAGE_PREV = 5;
    localparam int PIN_EVENT_PREV = 6;
    localparam int PIN_EVENT_NEXT = 7;

    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int SEC_PER_MIN = 60;
    localparam int PERIOD_RUN_MIN = 30;
    localparam int PERIOD_ANY_MIN = 60;
    localparam int PERIOD_RUN_S = PERIOD_RUN_MIN * SEC_PER_MIN;
    localparam int PERIOD_ANY_S = PERIOD_ANY_MIN * SEC_PER_MIN;
    localparam int SEC_W = 12;

    // front panel
    localparam int PASS_SKIP_PRESSES = 4;
    localparam int PRESS_W = 3;

    typedef enum logic [1:0] {
        VW_OFF,
        VW_PASSWORD,
        VW_LIST,
        VW_SHOW
    } view_state_t;
endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // raw pins
    input wire logic [W-1:0] pin_i,
    // synchronised level and rising edge
    output logic [W-1:0] level_o,
    output logic [W-1:0] rise_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;
    logic [W-1:0] last_reg;
    logic [W-1:0] last_next;

    // first stage feeds only the second stage
    always_comb begin
        meta_next = pin_i;
        sync_next = meta_reg;
        last_next = sync_reg;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    assign level_o = sync_reg;
    assign rise_o = sync_reg & ~last_reg;
endmodule

// *** rtl/event_log_recorder.sv ***
`timescale 1ns/1ns
module event_log_recorder #(
    parameter int DEPTH = evlog_pkg::DEPTH,
    parameter int SNAP_W = evlog_pkg::SNAP_W,
    parameter int SEC_CYCLES = evlog_pkg::CLK_HZ
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // per source enables
    input wire logic [evlog_pkg::N_SRC-1:0] ev_enable_i,
    // controller status and measurements
    input wire logic program_mode_i,
    input wire logic [evlog_pkg::FAULT_W-1:0] pw_level_i,
    input wire logic [evlog_pkg::MODE_W-1:0] op_mode_i,
    input wire logic [evlog_pkg::STAT_W-1:0] op_status_i,
    input wire logic engine_running_i,
    input wire logic genset_on_load_i,
    input wire logic shutdown_i,
    input wire logic loaddump_i,
    input wire logic warning_i,
    input wire logic [evlog_pkg::FAULT_W-1:0] fault_code_i,
    input wire logic [evlog_pkg::DT_W-1:0] datetime_i,
    input wire logic [evlog_pkg::HRS_W-1:0] engine_hours_i,
    input wire logic [SNAP_W-1:0] snapshot_i,
    // mains evaluation
    input wire logic mains_volt_ok_i,
    input wire logic mains_freq_ok_i,
    input wire logic phase_order_check_i,
    input wire logic phase_order_ok_i,
    input wire logic remote_start_defined_i,
    input wire logic remote_start_i,
    input wire logic simulate_mains_i,
    input wire logic forced_run_request_i,
    // front panel buttons
    input wire logic btn_menu_i,
    input wire logic btn_page_next_i,
    input wire logic btn_page_prev_i,
    input wire logic btn_event_prev_i,
    input wire logic btn_event_next_i,
    // status and display
    output logic mains_avail_o,
    output logic list_screen_o,
    output logic log_view_o,
    output logic [$clog2(DEPTH)-1:0] view_index_o,
    output logic [3:0] view_page_o,
    output logic [evlog_pkg::PAGE_W-1:0] view_data_o,
    output logic [$clog2(DEPTH+1)-1:0] record_count_o,
    output logic [evlog_pkg::NUM_W-1:0] last_event_num_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int NS = evlog_pkg::N_SRC;
    localparam int PAGES = evlog_pkg::HDR_PAGES + SNAP_W / evlog_pkg::PAGE_W;
    localparam int REC_W = evlog_pkg::HDR_PAGES * evlog_pkg::PAGE_W + SNAP_W;
    localparam logic [3:0] LAST_PAGE = 4'(PAGES - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);

    function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p,
                                               input logic up);
        logic [AW-1:0] r;
        r = up ? AW'(p + 1'b1) : AW'(p - 1'b1);
        if (up && p == AW'(DEPTH - 1))
            r = '0;
        if (!up && p == '0)
            r = AW'(DEPTH - 1);
        return r;
    endfunction

    function automatic logic [evlog_pkg::SEC_W-1:0] sec_step(
        input logic [evlog_pkg::SEC_W-1:0] s, input logic tick,
        input int last, output logic hit);
        hit = tick && s == evlog_pkg::SEC_W'(last - 1);
        if (hit)
            return '0;
        return tick ? evlog_pkg::SEC_W'(s + 1'b1) : s;
    endfunction

    // pins from outside the clock domain
    logic [evlog_pkg::N_PIN-1:0] pin_lvl;
    logic [evlog_pkg::N_PIN-1:0] pin_rise;

    pin_sync #(
        .W(evlog_pkg::N_PIN)
    ) u_pins (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .pin_i({btn_event_next_i, btn_event_prev_i, btn_page_prev_i,
                btn_page_next_i, btn_menu_i, forced_run_request_i,
                simulate_mains_i, remote_start_i}),
        .level_o(pin_lvl),
        .rise_o(pin_rise)
    );

    // mains status
    logic mains_reg;
    logic mains_next;

    always_comb begin
        mains_next = mains_volt_ok_i & mains_freq_ok_i &
                     (~phase_order_check_i | phase_order_ok_i);
        if (pin_lvl[evlog_pkg::PIN_SIMULATE])
            mains_next = 1'b1;
        if (pin_lvl[evlog_pkg::PIN_FORCED])
            mains_next = 1'b0;
        if (remote_start_defined_i)
            mains_next = ~pin_lvl[evlog_pkg::PIN_REMOTE];
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            mains_reg <= 1'b0;
        else
            mains_reg <= mains_next;
    end

    // periodic timers
    logic [31:0] cyc_reg;
    logic [31:0] cyc_next;
    logic [evlog_pkg::SEC_W-1:0] run_s_reg;
    logic [evlog_pkg::SEC_W-1:0] run_s_next;
    logic [evlog_pkg::SEC_W-1:0] any_s_reg;
    logic [evlog_pkg::SEC_W-1:0] any_s_next;
    logic sec_tick;
    logic run_hit;
    logic any_hit;

    always_comb begin
        sec_tick = cyc_reg == SEC_LAST;
        cyc_next = sec_tick ? '0 : cyc_reg + 32'h0000_0001;
        // running time restarts whenever the engine stops
        run_s_next = sec_step(run_s_reg, sec_tick,
                              evlog_pkg::PERIOD_RUN_S, run_hit);
        if (!engine_running_i) begin
            run_s_next = '0;
            run_hit = 1'b0;
        end
        any_s_next = sec_step(any_s_reg, sec_tick,
                              evlog_pkg::PERIOD_ANY_S, any_hit);
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cyc_reg <= '0;
            run_s_reg <= '0;
            any_s_reg <= '0;
        end else begin
            cyc_reg <= cyc_next;
            run_s_reg <= run_s_next;
            any_s_reg <= any_s_next;
        end
    end

    // event detection and pending flags
    logic primed_reg;
    logic [1:0] settle_reg;
    logic [1:0] settle_next;
    logic pmode_prev_reg;
    logic [evlog_pkg::MODE_W-1:0] mode_prev_reg;
    logic [5:0] lvl_prev_reg;
    logic [5:0] lvl_now;
    logic [NS-1:0] pend_reg;
    logic [NS-1:0] pend_next;
    logic [NS-1:0] new_ev;
    logic [NS-1:0] grant;
    logic [evlog_pkg::TYPE_W-1:0] grant_type;
    logic [evlog_pkg::FAULT_W-1:0] pgm_lvl_reg;
    logic [evlog_pkg::FAULT_W-1:0] pgm_lvl_next;
    logic program_entry_event;

    always_comb begin
        lvl_now = {shutdown_i, loaddump_i, warning_i,
                   mains_reg, engine_running_i, genset_on_load_i};
        program_entry_event = primed_reg & program_mode_i & ~pmode_prev_reg;
        new_ev = '0;
        if (primed_reg) begin
            new_ev[evlog_pkg::SRC_PGM] = program_entry_event;
            new_ev[evlog_pkg::SRC_PERIODIC] = run_hit | any_hit;
            new_ev[evlog_pkg::SRC_MODE] = op_mode_i != mode_prev_reg;
            new_ev[evlog_pkg::SRC_SHUTDOWN] = lvl_now[5] & ~lvl_prev_reg[5];
            new_ev[evlog_pkg::SRC_LOADDUMP] = lvl_now[4] & ~lvl_prev_reg[4];
            new_ev[evlog_pkg::SRC_WARNING] = lvl_now[3] & ~lvl_prev_reg[3];
            new_ev[evlog_pkg::SRC_MAINS_FAIL] = ~lvl_now[2] & lvl_prev_reg[2];
            new_ev[evlog_pkg::SRC_MAINS_RESTORE] = lvl_now[2] & ~lvl_prev_reg[2];
            new_ev[evlog_pkg::SRC_ENG_START] = lvl_now[1] & ~lvl_prev_reg[1];
            new_ev[evlog_pkg::SRC_ENG_STOP] = ~lvl_now[1] & lvl_prev_reg[1];
            new_ev[evlog_pkg::SRC_ON_LOAD] = lvl_now[0] & ~lvl_prev_reg[0];
            new_ev[evlog_pkg::SRC_OFF_LOAD] = ~lvl_now[0] & lvl_prev_reg[0];
        end
        // mains status needs the pin sync to settle, no false edge at start
        settle_next = settle_reg;
        if (primed_reg && !(&settle_reg))
            settle_next = 2'(settle_reg + 1'b1);
        if (!(&settle_reg))
            new_ev[evlog_pkg::SRC_MAINS_FAIL +: 2] = 2'h0;
        new_ev = new_ev & ev_enable_i;
        // one record per cycle, lowest source first
        grant = pend_reg & (~pend_reg + NS'(1));
        grant_type = '0;
        for (int i = 0; i < NS; i++) begin
            if (grant[i])
                grant_type = evlog_pkg::TYPE_W'(i);
        end
        // a new event beats the clear of its own flag
        pend_next = (pend_reg & ~grant) | new_ev;
        pgm_lvl_next = program_entry_event ? pw_level_i : pgm_lvl_reg;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            primed_reg <= 1'b0;
            settle_reg <= 2'h0;
            pmode_prev_reg <= 1'b0;
            mode_prev_reg <= '0;
            lvl_prev_reg <= '0;
            pend_reg <= '0;
            pgm_lvl_reg <= '0;
        end else begin
            primed_reg <= 1'b1;
            settle_reg <= settle_next;
            pmode_prev_reg <= program_mode_i;
            mode_prev_reg <= op_mode_i;
            lvl_prev_reg <= lvl_now;
            pend_reg <= pend_next;
            pgm_lvl_reg <= pgm_lvl_next;
        end
    end

    // record storage, flip-flop array
    logic [REC_W-1:0] mem [DEPTH];
    logic [REC_W-1:0] rec;
    logic mem_we;
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] wr_ptr_next;
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic [evlog_pkg::NUM_W-1:0] evnum_reg;
    logic [evlog_pkg::NUM_W-1:0] evnum_next;
    logic [evlog_pkg::FAULT_W-1:0] fault_sel;

    always_comb begin
        mem_we = |grant;
        fault_sel = grant[evlog_pkg::SRC_PGM] ? pgm_lvl_reg : fault_code_i;
        wr_ptr_next = wr_ptr_reg;
        count_next = count_reg;
        evnum_next = evnum_reg + 16'h0001;
        if (mem_we) begin
            // full array wraps onto the oldest record
            wr_ptr_next = ptr_step(wr_ptr_reg, 1'b1);
            count_next = (count_reg == FULL) ? FULL : CW'(count_reg + 1'b1);
        end else begin
            evnum_next = evnum_reg;
        end
        rec = {snapshot_i, {evlog_pkg::PAGE1_PAD_W{1'b0}}, engine_hours_i,
               op_status_i, op_mode_i, 4'h0, datetime_i, fault_sel,
               grant_type, evnum_next};
    end

    always_ff @(posedge ref_clk_i) begin
        if (mem_we)
            mem[wr_ptr_reg] <= rec;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr_reg <= '0;
            count_reg <= '0;
            evnum_reg <= evlog_pkg::EVNUM_RESET;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            count_reg <= count_next;
            evnum_reg <= evnum_next;
        end
    end

    // front panel viewer
    evlog_pkg::view_state_t vstate_reg;
    evlog_pkg::view_state_t vstate_next;
    logic [evlog_pkg::PRESS_W-1:0] press_reg;
    logic [evlog_pkg::PRESS_W-1:0] press_next;
    logic [AW-1:0] idx_reg;
    logic [AW-1:0] idx_next;
    logic [3:0] page_reg;
    logic [3:0] page_next;
    logic [evlog_pkg::PAGE_W-1:0] data_next;
    logic [AW-1:0] newest;
    logic [AW-1:0] oldest;

    always_comb begin
        vstate_next = vstate_reg;
        press_next = press_reg;
        idx_next = idx_reg;
        page_next = page_reg;
        newest = ptr_step(wr_ptr_reg, 1'b0);
        oldest = (count_reg == FULL) ? wr_ptr_reg : '0;
        unique case (vstate_reg)
            evlog_pkg::VW_OFF: begin
                press_next = '0;
                if (program_entry_event)
                    vstate_next = evlog_pkg::VW_PASSWORD;
            end
            evlog_pkg::VW_PASSWORD: begin
                if (pin_rise[evlog_pkg::PIN_MENU]) begin
                    press_next = press_reg + 1'b1;
                    if (press_reg == evlog_pkg::PRESS_W'(
                            evlog_pkg::PASS_SKIP_PRESSES - 1))
                        vstate_next = evlog_pkg::VW_LIST;
                end
            end
            evlog_pkg::VW_LIST: begin
                // nothing to open while the log is empty
                if (pin_rise[evlog_pkg::PIN_MENU] && count_reg != '0) begin
                    vstate_next = evlog_pkg::VW_SHOW;
                    idx_next = newest;
                    page_next = '0;
                end
            end
            evlog_pkg::VW_SHOW: begin
                if (pin_rise[evlog_pkg::PIN_PAGE_NEXT])
                    page_next = (page_reg == LAST_PAGE) ? 4'h0 :
                                4'(page_reg + 1'b1);
                else if (pin_rise[evlog_pkg::PIN_PAGE_PREV])
                    page_next = (page_reg == 4'h0) ? LAST_PAGE :
                                4'(page_reg - 1'b1);
                else if (pin_rise[evlog_pkg::PIN_EVENT_PREV] &&
                         idx_reg != oldest)
                    idx_next = ptr_step(idx_reg, 1'b0);
                else if (pin_rise[evlog_pkg::PIN_EVENT_NEXT] &&
                         idx_reg != newest)
                    idx_next = ptr_step(idx_reg, 1'b1);
            end
        endcase
        if (!program_mode_i)
            vstate_next = evlog_pkg::VW_OFF;
        data_next = mem[idx_next][page_next * evlog_pkg::PAGE_W +:
                                  evlog_pkg::PAGE_W];
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            vstate_reg <= evlog_pkg::VW_OFF;
            press_reg <= '0;
            idx_reg <= '0;
            page_reg <= '0;
            view_data_o <= '0;
            list_screen_o <= 1'b0;
            log_view_o <= 1'b0;
            mains_avail_o <= 1'b0;
        end else begin
            vstate_reg <= vstate_next;
            press_reg <= press_next;
            idx_reg <= idx_next;
            page_reg <= page_next;
            view_data_o <= (vstate_next == evlog_pkg::VW_SHOW) ?
                           data_next : '0;
            list_screen_o <= vstate_next == evlog_pkg::VW_LIST;
            log_view_o <= vstate_next == evlog_pkg::VW_SHOW;
            mains_avail_o <= mains_next;
        end
    end

    assign view_index_o = idx_reg;
    assign view_page_o = page_reg;
    assign record_count_o = count_reg;
    assign last_event_num_o = evnum_reg;
endmodule

// *** sim/evlog_checker.sv ***
`timescale 1ns/1ns
module evlog_checker #(
    parameter int DEPTH = 512
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // watched inputs
    input wire logic [evlog_pkg::N_SRC-1:0] ev_enable_i,
    input wire logic program_mode_i,
    input wire logic engine_running_i,
    input wire logic mains_volt_ok_i,
    input wire logic mains_freq_ok_i,
    input wire logic phase_order_check_i,
    input wire logic phase_order_ok_i,
    input wire logic remote_start_defined_i,
    input wire logic remote_start_i,
    input wire logic simulate_mains_i,
    input wire logic forced_run_request_i,
    // watched outputs
    input wire logic mains_avail_o,
    input wire logic list_screen_o,
    input wire logic log_view_o,
    input wire logic [$clog2(DEPTH)-1:0] view_index_o,
    input wire logic [3:0] view_page_o,
    input wire logic [evlog_pkg::PAGE_W-1:0] view_data_o,
    input wire logic [$clog2(DEPTH+1)-1:0] record_count_o,
    input wire logic [evlog_pkg::NUM_W-1:0] last_event_num_o
);
    logic [2:0] quiet_reg;
    logic [2:0] quiet_next;
    logic quiet;
    // override pins pass a 2-flop sync, so wait them out
    assign quiet = !(simulate_mains_i | forced_run_request_i |
        remote_start_defined_i | remote_start_i);
    always_comb begin
        quiet_next = 3'h0;
        if (quiet) begin
            quiet_next = (quiet_reg == 3'h7) ? quiet_reg : quiet_reg + 3'h1;
        end
    end
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            quiet_reg <= 3'h0;
        end else begin
            quiet_reg <= quiet_next;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    a_mains_eval: assert property (quiet_reg >= 3'h5 |-> mains_avail_o ==
        $past(mains_volt_ok_i & mains_freq_ok_i &
        (!phase_order_check_i | phase_order_ok_i)))
        else $error("mains availability wrong");
    a_count_step: assert property ($changed(record_count_o) |->
        record_count_o == $past(record_count_o) + 1'b1)
        else $error("record count jumped");
    a_num_step: assert property ($changed(last_event_num_o) |->
        last_event_num_o == $past(last_event_num_o) + 1'b1)
        else $error("event number jumped");
    a_num_with_count: assert property ($changed(record_count_o) |->
        $changed(last_event_num_o))
        else $error("record stored without number");
    a_page_range: assert property (view_page_o <= 4'h6)
        else $error("page out of range");
    a_data_idle: assert property (!log_view_o |-> view_data_o == '0)
        else $error("page data shown while idle");
    a_view_exit: assert property (!program_mode_i |=>
        !log_view_o && !list_screen_o)
        else $error("log screens outside program mode");
    a_page_keeps_event: assert property ($changed(view_page_o) &&
        log_view_o && $past(log_view_o) |-> $stable(view_index_o))
        else $error("page step moved the record");
    a_event_keeps_page: assert property ($changed(view_index_o) &&
        log_view_o && $past(log_view_o) |-> $stable(view_page_o))
        else $error("record step moved the page");
    a_start_record: assert property ($rose(engine_running_i) &&
        ev_enable_i[evlog_pkg::SRC_ENG_START] |->
        ##[1:14] $changed(last_event_num_o))
        else $error("engine start not recorded");
endmodule
bind event_log_recorder evlog_checker #(.DEPTH(DEPTH)) i_evlog_checker (
    .ref_clk_i, .arst_n_i, .ev_enable_i, .program_mode_i, .engine_running_i,
    .mains_volt_ok_i, .mains_freq_ok_i, .phase_order_check_i,
    .phase_order_ok_i, .remote_start_defined_i, .remote_start_i,
    .simulate_mains_i, .forced_run_request_i, .mains_avail_o,
    .list_screen_o, .log_view_o, .view_index_o, .view_page_o, .view_data_o,
    .record_count_o, .last_event_num_o);

// *** sim/panel_model.sv ***
`timescale 1ns/1ns
module panel_model (
    // clock
    input wire logic ref_clk_i,
    // buttons, low when released
    output logic btn_menu_o,
    output logic btn_page_next_o,
    output logic btn_page_prev_o,
    output logic btn_event_prev_o,
    output logic btn_event_next_o
);
    logic [4:0] btn = 5'h00;
    assign {btn_event_next_o, btn_event_prev_o, btn_page_prev_o,
        btn_page_next_o, btn_menu_o} = btn;
    // held 4 cycles so the 2-flop sync cannot miss a press
    task automatic press(input int b, input int n);
        repeat (n) begin
            @(negedge ref_clk_i);
            btn[b] = 1'b1;
            repeat (4) @(negedge ref_clk_i);
            btn[b] = 1'b0;
            repeat (6) @(negedge ref_clk_i);
        end
    endtask
    // four menu presses pass the password screen
    task automatic skip_password;
        press(0, 4);
    endtask
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    localparam int SECC = 4;
    localparam int RUN_CYC = evlog_pkg::PERIOD_RUN_S * SECC;
    localparam int ANY_CYC = evlog_pkg::PERIOD_ANY_S * SECC;
    // volt freq chk order sim forced rdef remote, expected
    localparam logic [8:0] MT [8] = '{9'h181, 9'h100, 9'h1E1, 9'h1C0,
        9'h091, 9'h188, 9'h005, 9'h186};
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [evlog_pkg::N_SRC-1:0] ev_enable_i = '0;
    logic program_mode_i = 1'b0, engine_running_i = 1'b0;
    logic genset_on_load_i = 1'b0, shutdown_i = 1'b0;
    logic loaddump_i = 1'b0, warning_i = 1'b0;
    logic [7:0] pw_level_i = 8'h03, op_status_i = 8'hC5;
    logic [7:0] fault_code_i = 8'h5A;
    logic [2:0] op_mode_i = 3'h1;
    logic [31:0] datetime_i = 32'h1234ABCD, engine_hours_i = 32'h00000BEE;
    logic [evlog_pkg::SNAP_W-1:0] snapshot_i;
    logic mains_volt_ok_i, mains_freq_ok_i, phase_order_check_i;
    logic phase_order_ok_i, remote_start_defined_i, remote_start_i;
    logic simulate_mains_i, forced_run_request_i;
    logic btn_menu_i, btn_page_next_i, btn_page_prev_i;
    logic btn_event_prev_i, btn_event_next_i;
    logic mains_avail_o, list_screen_o, log_view_o;
    logic [8:0] view_index_o;
    logic [3:0] view_page_o;
    logic [63:0] view_data_o;
    logic [9:0] record_count_o, cnt_exp = 10'h000;
    logic [15:0] last_event_num_o, num_exp = 16'h0000;
    int n_mismatch = 0, n_checks = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    event_log_recorder #(.SEC_CYCLES(SECC)) i_event_log_recorder (
        .ref_clk_i, .arst_n_i, .ev_enable_i, .program_mode_i, .pw_level_i,
        .op_mode_i, .op_status_i, .engine_running_i, .genset_on_load_i,
        .shutdown_i, .loaddump_i, .warning_i, .fault_code_i, .datetime_i,
        .engine_hours_i, .snapshot_i, .mains_volt_ok_i, .mains_freq_ok_i,
        .phase_order_check_i, .phase_order_ok_i, .remote_start_defined_i,
        .remote_start_i, .simulate_mains_i, .forced_run_request_i,
        .btn_menu_i, .btn_page_next_i, .btn_page_prev_i, .btn_event_prev_i,
        .btn_event_next_i, .mains_avail_o, .list_screen_o, .log_view_o,
        .view_index_o, .view_page_o, .view_data_o, .record_count_o,
        .last_event_num_o);
    panel_model i_panel_model (.ref_clk_i, .btn_menu_o(btn_menu_i),
        .btn_page_next_o(btn_page_next_i), .btn_page_prev_o(btn_page_prev_i),
        .btn_event_prev_o(btn_event_prev_i),
        .btn_event_next_o(btn_event_next_i));
    task check(input string what, input logic [63:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task set_mains(input logic [7:0] v);
        {mains_volt_ok_i, mains_freq_ok_i, phase_order_check_i,
            phase_order_ok_i, simulate_mains_i, forced_run_request_i,
            remote_start_defined_i, remote_start_i} = v;
    endtask
    task t_mains;
        for (int i = 0; i < 8; i++) begin
            set_mains(MT[i][8:1]);
            cyc(6);
            check("mains", mains_avail_o, MT[i][0]);
        end
        set_mains(8'hC0);
        cyc(6);
        $display("test mains done");
    endtask
    task ev(input int s, input bit en);
        ev_enable_i = en ? (12'h001 << s) : '0;
        case (s)
            0: program_mode_i = 1'b1;
            2: op_mode_i = op_mode_i ^ 3'h3;
            3: shutdown_i = 1'b1;
            4: loaddump_i = 1'b1;
            5: warning_i = 1'b1;
            6: mains_volt_ok_i = 1'b0;
            7: mains_volt_ok_i = 1'b1;
            8: engine_running_i = 1'b1;
            9: engine_running_i = 1'b0;
            10: genset_on_load_i = 1'b1;
            default: genset_on_load_i = 1'b0;
        endcase
        cyc(20);
        if (en) begin
            cnt_exp++;
            num_exp++;
        end
        check("count", record_count_o, cnt_exp);
        check("number", last_event_num_o, num_exp);
        {program_mode_i, shutdown_i, loaddump_i, warning_i} = 4'h0;
        ev_enable_i = '0;
        cyc(4);
    endtask
    task t_events;
        // disabled pass first; paired sources come back to rest each pass
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 12; s++) if (s != 1) ev(s, p[0]);
        end
        $display("test events done");
    endtask
    task t_view;
        ev_enable_i = 12'h001;
        program_mode_i = 1'b1;
        cyc(20);
        num_exp++;
        i_panel_model.skip_password();
        check("list", list_screen_o, 1'b1);
        i_panel_model.press(0, 1);
        check("view", log_view_o, 1'b1);
        check("page", view_page_o, 4'h0);
        check("index", view_index_o, 9'h00B);
        check("page0", view_data_o, {4'h0, datetime_i, pw_level_i,
            4'h0, num_exp});
        i_panel_model.press(1, 1);
        check("page1", view_data_o, {21'h0, engine_hours_i,
            op_status_i, op_mode_i});
        i_panel_model.press(2, 2);
        check("page", view_page_o, 4'h6);
        check("page6", view_data_o, snapshot_i[319:256]);
        i_panel_model.press(3, 1);
        check("page", view_page_o, 4'h6);
        i_panel_model.press(1, 1);
        check("older", view_data_o[15:0], num_exp - 16'h1);
        i_panel_model.press(4, 2);
        check("newest", view_data_o[15:0], num_exp);
        program_mode_i = 1'b0;
        ev_enable_i = '0;
        cyc(2);
        check("closed", log_view_o, 1'b0);
        $display("test viewer done");
    endtask
    task wait_rec(input int lim);
        logic [15:0] n0;
        n0 = last_event_num_o;
        while (last_event_num_o === n0 && lim > 0) begin
            cyc(1);
            lim--;
        end
        check("periodic", last_event_num_o, n0 + 16'h1);
    endtask
    task t_periodic;
        ev_enable_i = 12'h002;
        wait_rec(ANY_CYC + 40);
        num_exp = last_event_num_o;
        cyc(ANY_CYC - 20);
        check("early", last_event_num_o, num_exp);
        wait_rec(40);
        // run timer only counts from the engine start
        engine_running_i = 1'b1;
        num_exp = last_event_num_o;
        cyc(RUN_CYC - 20);
        check("early", last_event_num_o, num_exp);
        wait_rec(40);
        engine_running_i = 1'b0;
        $display("test periodic done");
    endtask
    initial begin
        set_mains(8'hC0);
        for (int i = 0; i < 5; i++) snapshot_i[i*64+:64] = 64'hA0 + 64'(i);
        cyc(8);
        arst_n_i = 1'b1;
        cyc(4);
        t_mains;
        t_events;
        t_view;
        t_periodic;
        results;
    end
    initial begin
        #(45000 * 50);
        n_mismatch++;
        $display("watchdog expired");
        results;
    end
endmodule
